// ---- verilog/sef_pkg.sv ----
// Constants, opcodes, status layout and state encodings of the serial EEPROM front end.
// Assumes a 50 MHz system clock and a host that supplies the serial clock.
package sef_pkg;

	// ------------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_SET_WE       = 8'h06;
	localparam logic [7:0] OP_CLR_WE       = 8'h04;
	localparam logic [7:0] OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_WRITE        = 8'h02;

	// ------------------------------------------------------------------
	// Widths and storage
	// ------------------------------------------------------------------
	localparam int BYTE_W     = 8;
	localparam int ADDR_W     = 16;
	localparam int MAIN_AW    = 8;
	localparam int MAIN_DEPTH = 256;
	localparam int ID_AW      = 6;
	localparam int ID_DEPTH   = 64;
	localparam int PAGE_AW    = 6;
	localparam int BIT_CNT_W  = 3;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;

	// ------------------------------------------------------------------
	// Status byte layout
	// ------------------------------------------------------------------
	localparam int ST_BUSY  = 0;
	localparam int ST_WEL   = 1;
	localparam int ST_BP0   = 2;
	localparam int ST_BP1   = 3;
	localparam int ST_LOCK  = 4;
	localparam int ST_ZERO  = 5;
	localparam int ST_IDSEL = 6;
	localparam int ST_PEN   = 7;
	localparam logic [1:0] BP_FULL = 2'h3;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ        = 50_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int WRITE_TIME_MS = 4;
	localparam int WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / MS_PER_S);
	// Cycles lost between the chip select rise and the busy flag going high.
	localparam int CDC_LAT       = 4;
	localparam int TIMER_W       = 18;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SEF_OPCODE  = 3'h0,
		SEF_ADDR_HI = 3'h1,
		SEF_ADDR_LO = 3'h3,
		SEF_DATA    = 3'h2,
		SEF_SKIP    = 3'h6
	} sef_state_t;

	typedef enum logic [2:0] {
		EV_SET_WE = 3'h0,
		EV_CLR_WE = 3'h1,
		EV_STATUS = 3'h2,
		EV_MEM    = 3'h3,
		EV_READ   = 3'h4
	} sef_event_t;

endpackage

// ---- verilog/sef_sync.sv ----
// Two flip-flop level synchroniser, one bit per lane.
// Assumes each lane is a level that stays put for at least two destination clocks.
`timescale 1ns/100ps

module sef_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;

endmodule // sef_sync

// ---- verilog/sef_top.sv ----
// Serial slave front end of an SPI EEPROM: frame decode on the serial clock, status,
// protection, storage and the self-timed write on the system clock.
// Assumes the host keeps chip select, serial input and hold within setup and hold of the
// serial clock, and changes hold only while the serial clock is low.
`timescale 1ns/100ps

module sef_top #(
	parameter int WRITE_CYCLES = sef_pkg::WRITE_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       si_i,
	input  wire logic       hold_n_i,
	input  wire logic       wp_n_i,
	output logic            so_o,
	output logic            so_oe_o,
	output logic            busy_o,
	output logic            write_enable_o,
	output logic            standby_o,
	output logic      [7:0] status_o
);

	// ------------------------------------------------------------------
	// Serial clock domain
	// ------------------------------------------------------------------
	logic                               frame_rst;
	sef_pkg::sef_state_t                state_ff;
	sef_pkg::sef_state_t                nxt_state;
	logic [sef_pkg::BIT_CNT_W-1:0]      bit_cnt_ff;
	logic [sef_pkg::BYTE_W-2:0]         shift_ff;
	logic [sef_pkg::BYTE_W-1:0]         opcode_ff;
	logic [sef_pkg::ADDR_W-1:0]         addr_ff;
	logic [sef_pkg::ADDR_W-1:0]         nxt_addr;
	logic [sef_pkg::BYTE_W-1:0]         byte_in;
	logic                               byte_done;
	logic                               take_edge;
	logic                               post;
	sef_pkg::sef_event_t                post_kind;
	logic                               ev_tgl_ff;
	sef_pkg::sef_event_t                ev_kind_ff;
	logic [sef_pkg::BYTE_W-1:0]         ev_data_ff;
	logic [sef_pkg::ADDR_W-1:0]         ev_addr_ff;
	logic [sef_pkg::BYTE_W-1:0]         status_sck;
	logic [sef_pkg::BYTE_W-1:0]         tx_byte;
	logic [sef_pkg::BYTE_W-1:0]         mem_rd_byte;
	logic                               out_phase;
	logic                               so_ff;
	logic [sef_pkg::BYTE_W-1:0]         main_mem_ff [sef_pkg::MAIN_DEPTH];
	logic [sef_pkg::BYTE_W-1:0]         id_mem_ff   [sef_pkg::ID_DEPTH];

	// Chip select high clears the frame so every session starts at the opcode.
	assign frame_rst = rst_i | cs_n_i;
	assign take_edge = hold_n_i;
	assign byte_done = (bit_cnt_ff == sef_pkg::LAST_BIT);
	assign byte_in   = {shift_ff, si_i};

	always_ff @(posedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			shift_ff   <= '0;
			bit_cnt_ff <= '0;
		end else if (take_edge) begin
			shift_ff   <= byte_in[sef_pkg::BYTE_W-2:0];
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_addr  = addr_ff;
		post      = 1'b0;
		post_kind = sef_pkg::EV_READ;
		if (byte_done) begin
			case (state_ff)
				sef_pkg::SEF_OPCODE: begin
					if (status_sck[sef_pkg::ST_BUSY] && (byte_in != sef_pkg::OP_READ_STATUS)) begin
						nxt_state = sef_pkg::SEF_SKIP;
					end else begin
						case (byte_in)
							sef_pkg::OP_READ_STATUS: begin
								nxt_state = sef_pkg::SEF_DATA;
							end
							sef_pkg::OP_WRITE_STATUS: begin
								nxt_state = sef_pkg::SEF_DATA;
							end
							sef_pkg::OP_READ, sef_pkg::OP_WRITE: begin
								nxt_state = sef_pkg::SEF_ADDR_HI;
							end
							sef_pkg::OP_SET_WE: begin
								post      = 1'b1;
								post_kind = sef_pkg::EV_SET_WE;
								nxt_state = sef_pkg::SEF_SKIP;
							end
							sef_pkg::OP_CLR_WE: begin
								post      = 1'b1;
								post_kind = sef_pkg::EV_CLR_WE;
								nxt_state = sef_pkg::SEF_SKIP;
							end
							default: begin
								nxt_state = sef_pkg::SEF_SKIP;
							end
						endcase
					end
				end
				sef_pkg::SEF_ADDR_HI: begin
					nxt_addr[sef_pkg::ADDR_W-1:sef_pkg::BYTE_W] = byte_in;
					nxt_state = sef_pkg::SEF_ADDR_LO;
				end
				sef_pkg::SEF_ADDR_LO: begin
					nxt_addr[sef_pkg::BYTE_W-1:0] = byte_in;
					nxt_state = sef_pkg::SEF_DATA;
					if (opcode_ff == sef_pkg::OP_READ) begin
						post      = 1'b1;
						post_kind = sef_pkg::EV_READ;
					end
				end
				sef_pkg::SEF_DATA: begin
					case (opcode_ff)
						sef_pkg::OP_WRITE_STATUS: begin
							post      = 1'b1;
							post_kind = sef_pkg::EV_STATUS;
						end
						// each data byte posted, page rolls over
						sef_pkg::OP_WRITE: begin
							post      = 1'b1;
							post_kind = sef_pkg::EV_MEM;
							nxt_addr[sef_pkg::PAGE_AW-1:0] =
								addr_ff[sef_pkg::PAGE_AW-1:0] + 6'h01;
						end
						sef_pkg::OP_READ: begin
							nxt_addr = addr_ff + 16'h0001;
						end
						default: begin
							nxt_state = state_ff;
						end
					endcase
				end
				default: begin
					nxt_state = sef_pkg::SEF_SKIP;
				end
			endcase
		end
	end

	always_ff @(posedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			state_ff <= sef_pkg::SEF_OPCODE;
			addr_ff  <= '0;
		end else if (take_edge) begin
			state_ff <= nxt_state;
			addr_ff  <= nxt_addr;
		end
	end

	always_ff @(posedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			opcode_ff <= '0;
		end else if (take_edge && byte_done && (state_ff == sef_pkg::SEF_OPCODE)) begin
			opcode_ff <= byte_in;
		end
	end

	// Event words survive chip select so the toggle never makes a false edge. Payload is held
	// for at least eight serial clocks, far longer than the crossing takes.
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			ev_tgl_ff  <= 1'b0;
			ev_kind_ff <= sef_pkg::EV_READ;
			ev_data_ff <= '0;
			ev_addr_ff <= '0;
		end else if (take_edge && !cs_n_i && post) begin
			ev_tgl_ff  <= ~ev_tgl_ff;
			ev_kind_ff <= post_kind;
			ev_data_ff <= byte_in;
			ev_addr_ff <= addr_ff;
		end
	end

	sef_sync #(
		.WIDTH   (sef_pkg::BYTE_W),
		.RST_VAL (8'h00)
	) u_status_sync (
		.clk_i (sck_i),
		.rst_i (rst_i),
		.d_i   (status_o),
		.q_o   (status_sck)
	);

	// The arrays belong to the system clock but are read here directly. Writes only happen
	// inside a write frame, before busy rises, and busy refuses reads, so the contents are still during any read.
	// id page steers reads
	assign mem_rd_byte = status_sck[sef_pkg::ST_IDSEL] ? id_mem_ff[addr_ff[sef_pkg::ID_AW-1:0]]
		: main_mem_ff[addr_ff[sef_pkg::MAIN_AW-1:0]];
	assign tx_byte     = (opcode_ff == sef_pkg::OP_READ_STATUS) ? status_sck : mem_rd_byte;
	assign out_phase   = (state_ff == sef_pkg::SEF_DATA) &&
		((opcode_ff == sef_pkg::OP_READ) || (opcode_ff == sef_pkg::OP_READ_STATUS));

	always_ff @(negedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			so_ff <= 1'b0;
		end else if (take_edge && out_phase) begin
			so_ff <= tx_byte[sef_pkg::LAST_BIT - bit_cnt_ff];
		end
	end

	assign so_o    = so_ff;
	assign so_oe_o = !cs_n_i && hold_n_i && out_phase;

	// ------------------------------------------------------------------
	// System clock domain
	// ------------------------------------------------------------------
	logic [2:0]                   sync_q;
	logic                         cs_s;
	logic                         wp_s;
	logic                         tgl_s;
	logic                         cs_prev_ff;
	logic                         tgl_prev_ff;
	logic                         ev_now;
	logic                         cs_rise;
	logic                         wel_ff;
	logic                         pen_ff;
	logic                         idsel_ff;
	logic                         lock_ff;
	logic [1:0]                   bp_ff;
	logic                         busy_ff;
	logic [sef_pkg::TIMER_W-1:0]  timer_ff;
	logic                         pend_set_ff;
	logic                         pend_clr_ff;
	logic                         pend_sr_ff;
	logic                         pend_mem_ff;
	logic                         pend_rd_ff;
	logic [sef_pkg::BYTE_W-1:0]   pend_data_ff;
	logic                         nxt_pend_set;
	logic                         nxt_pend_clr;
	logic                         nxt_pend_sr;
	logic                         nxt_pend_mem;
	logic                         nxt_pend_rd;
	logic [sef_pkg::BYTE_W-1:0]   nxt_pend_data;
	logic                         mem_ok;
	logic                         main_wr;
	logic                         id_wr;
	logic                         sr_ok;
	logic                         both_id;
	logic                         start_write;

	sef_sync #(
		.WIDTH   (3),
		.RST_VAL (3'h3)
	) u_pin_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({ev_tgl_ff, wp_n_i, cs_n_i}),
		.q_o   (sync_q)
	);

	assign cs_s  = sync_q[0];
	assign wp_s  = sync_q[1];
	assign tgl_s = sync_q[2];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_prev_ff  <= 1'b1;
			tgl_prev_ff <= 1'b0;
		end else begin
			cs_prev_ff  <= cs_s;
			tgl_prev_ff <= tgl_s;
		end
	end

	// The last event of a frame crosses no later than the chip select rise that ends it,
	// so both may land in one cycle and the event is folded in before the commit.
	assign ev_now  = tgl_s ^ tgl_prev_ff;
	assign cs_rise = cs_s & ~cs_prev_ff;

	// locked or fully protected id page refuses writes
	assign mem_ok  = ev_now && (ev_kind_ff == sef_pkg::EV_MEM) && wel_ff && !busy_ff &&
		!(idsel_ff && (lock_ff || (bp_ff == sef_pkg::BP_FULL)));
	assign main_wr = mem_ok && !idsel_ff;
	assign id_wr   = mem_ok && idsel_ff;

	always_comb begin
		nxt_pend_set  = pend_set_ff  | (ev_now && (ev_kind_ff == sef_pkg::EV_SET_WE));
		nxt_pend_clr  = pend_clr_ff  | (ev_now && (ev_kind_ff == sef_pkg::EV_CLR_WE));
		nxt_pend_sr   = pend_sr_ff   | (ev_now && (ev_kind_ff == sef_pkg::EV_STATUS));
		nxt_pend_rd   = pend_rd_ff   | (ev_now && (ev_kind_ff == sef_pkg::EV_READ));
		nxt_pend_mem  = pend_mem_ff  | mem_ok;
		nxt_pend_data = (ev_now && (ev_kind_ff == sef_pkg::EV_STATUS)) ? ev_data_ff : pend_data_ff;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_set_ff  <= 1'b0;
			pend_clr_ff  <= 1'b0;
			pend_sr_ff   <= 1'b0;
			pend_mem_ff  <= 1'b0;
			pend_rd_ff   <= 1'b0;
			pend_data_ff <= '0;
		end else begin
			pend_set_ff  <= nxt_pend_set  & ~cs_rise;
			pend_clr_ff  <= nxt_pend_clr  & ~cs_rise;
			pend_sr_ff   <= nxt_pend_sr   & ~cs_rise;
			pend_mem_ff  <= nxt_pend_mem  & ~cs_rise;
			pend_rd_ff   <= nxt_pend_rd   & ~cs_rise;
			pend_data_ff <= nxt_pend_data;
		end
	end

	assign sr_ok       = wel_ff && !busy_ff && !(pen_ff && !wp_s);
	assign both_id     = nxt_pend_data[sef_pkg::ST_IDSEL] && nxt_pend_data[sef_pkg::ST_LOCK];
	assign start_write = cs_rise && (nxt_pend_mem || (nxt_pend_sr && sr_ok));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wel_ff   <= 1'b0;
			pen_ff   <= 1'b0;
			idsel_ff <= 1'b0;
			lock_ff  <= 1'b0;
			bp_ff    <= '0;
		end else if (cs_rise) begin
			// latch follows its opcodes at frame end
			if (nxt_pend_set && !busy_ff) begin
				wel_ff <= 1'b1;
			end else if (nxt_pend_clr && !busy_ff) begin
				wel_ff <= 1'b0;
			end
			if (nxt_pend_sr && sr_ok) begin
				wel_ff <= 1'b0;
				pen_ff <= nxt_pend_data[sef_pkg::ST_PEN];
				bp_ff  <= nxt_pend_data[sef_pkg::ST_BP1:sef_pkg::ST_BP0];
				// Setting page select and lock together changes neither.
				if (!both_id) begin
					idsel_ff <= nxt_pend_data[sef_pkg::ST_IDSEL];
					lock_ff  <= lock_ff | nxt_pend_data[sef_pkg::ST_LOCK];
				end
			end
			if (nxt_pend_mem) begin
				wel_ff   <= 1'b0;
				idsel_ff <= 1'b0;
			end else if (nxt_pend_rd) begin
				idsel_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_ff  <= 1'b0;
			timer_ff <= '0;
		end else if (start_write) begin
			busy_ff  <= 1'b1;
			timer_ff <= sef_pkg::TIMER_W'(WRITE_CYCLES - sef_pkg::CDC_LAT - 1);
		end else if (busy_ff) begin
			if (timer_ff == '0) begin
				busy_ff <= 1'b0;
			end else begin
				timer_ff <= timer_ff - 18'h00001;
			end
		end
	end

	// Storage carries no reset; contents are undefined until written.
	// id page steers writes
	always_ff @(posedge clk_i) begin
		if (main_wr) begin
			main_mem_ff[ev_addr_ff[sef_pkg::MAIN_AW-1:0]] <= ev_data_ff;
		end
		if (id_wr) begin
			id_mem_ff[ev_addr_ff[sef_pkg::ID_AW-1:0]] <= ev_data_ff;
		end
	end

	assign busy_o         = busy_ff;
	assign write_enable_o = wel_ff;
	assign standby_o      = cs_s && !busy_ff;

	always_comb begin
		status_o                    = '0;
		status_o[sef_pkg::ST_BUSY]  = busy_ff;
		status_o[sef_pkg::ST_WEL]   = wel_ff;
		status_o[sef_pkg::ST_BP0]   = bp_ff[0];
		status_o[sef_pkg::ST_BP1]   = bp_ff[1];
		status_o[sef_pkg::ST_LOCK]  = lock_ff;
		status_o[sef_pkg::ST_ZERO]  = 1'b0;
		status_o[sef_pkg::ST_IDSEL] = idsel_ff;
		status_o[sef_pkg::ST_PEN]   = pen_ff;
	end

endmodule // sef_top

// ---- tb/sef_properties.sv ----
// Port-level assertions for the serial EEPROM front end.
// Assumes the host leaves at least 200 ns of chip select high between frames.
`timescale 1ns/100ps

module sef_properties #(
	parameter int WRITE_CYCLES = 64
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       si_i,
	input  wire logic       hold_n_i,
	input  wire logic       wp_n_i,
	input  wire logic       so_o,
	input  wire logic       so_oe_o,
	input  wire logic       busy_o,
	input  wire logic       write_enable_o,
	input  wire logic       standby_o,
	input  wire logic [7:0] status_o
);
	// Counts how long busy has stood, so the write time can be bounded.
	logic [17:0] busy_cnt_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_cnt_ff <= 18'h00000;
		end else if (busy_o) begin
			busy_cnt_ff <= busy_cnt_ff + 18'h00001;
		end else begin
			busy_cnt_ff <= 18'h00000;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_float_cs;
		cs_n_i |-> !so_oe_o;
	endproperty
	a_float_cs: assert property (p_float_cs) else $error("output driven with chip select high");

	property p_float_hold;
		!hold_n_i |-> !so_oe_o;
	endproperty
	a_float_hold: assert property (p_float_hold) else $error("output driven during hold");

	property p_standby;
		busy_o |-> !standby_o;
	endproperty
	a_standby: assert property (p_standby) else $error("standby while writing");

	property p_busy_bit;
		status_o[0] == busy_o;
	endproperty
	a_busy_bit: assert property (p_busy_bit) else $error("busy bit differs from busy");

	property p_wel_bit;
		status_o[1] == write_enable_o;
	endproperty
	a_wel_bit: assert property (p_wel_bit) else $error("latch bit differs from latch");

	property p_busy_len;
		busy_o |-> busy_cnt_ff < WRITE_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("internal write too long");

	property p_busy_start;
		$rose(busy_o) |-> $past(cs_n_i, 2);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("write began inside a frame");

	property p_no_wel_busy;
		$rose(write_enable_o) |-> !busy_o;
	endproperty
	a_no_wel_busy: assert property (p_no_wel_busy) else $error("latch set while busy");

	property p_lock;
		$past(status_o[4]) |-> status_o[4];
	endproperty
	a_lock: assert property (p_lock) else $error("page lock cleared");

	property p_wp;
		(!wp_n_i && $past(!wp_n_i, 4) && $past(status_o[7]))
			|-> status_o[7] && !$rose(status_o[4]) && !$rose(status_o[6]);
	endproperty
	a_wp: assert property (p_wp) else $error("status changed while protected");
endmodule // sef_properties

bind sef_top sef_properties #(.WRITE_CYCLES(WRITE_CYCLES)) sef_properties_inst (
	.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
	.hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
	.busy_o(busy_o), .write_enable_o(write_enable_o), .standby_o(standby_o),
	.status_o(status_o));

// ---- tb/sef_host.sv ----
// Host serial controller model: sends whole frames in mode 0 or 3 and captures the answer.
// Assumes the device drives so_i only while so_oe_i is high.
`timescale 1ns/100ps

module sef_host (
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o,
	output logic      hold_n_o,
	input  wire logic so_i,
	input  wire logic so_oe_i
);
	// Serial clock level between frames: low for mode 0, high for mode 3.
	logic idle_hi = 1'b0;

	initial begin
		sck_o    = 1'b0;
		cs_n_o   = 1'b1;
		si_o     = 1'b0;
		hold_n_o = 1'b1;
	end

	// The link clock stands at its idle level between frames; a floated output reads inverted.
	task automatic frame(input logic [7:0] tx[$], input int hold_at,
			output logic [7:0] rx[$], output logic oe_bad);
		logic [7:0] b;
		rx     = {};
		oe_bad = 1'b0;
		b      = 8'h00;
		sck_o  = idle_hi;
		#20;
		cs_n_o = 1'b0;
		#20;
		foreach (tx[i]) begin
			for (int k = 7; k >= 0; k--) begin
				sck_o = 1'b0;
				if (i * 8 + 7 - k == hold_at) begin
					hold_n_o = 1'b0;
					#50;
					oe_bad   = (so_oe_i !== 1'b0);
					hold_n_o = 1'b1;
					#20;
				end
				si_o  = tx[i][k];
				#16;
				sck_o = 1'b1;
				b[k]  = so_oe_i ? so_i : ~so_i;
				#16;
			end
			rx.push_back(b);
		end
		sck_o = idle_hi;
		#20;
		cs_n_o = 1'b1;
		si_o   = ~si_o;
		#200;
	endtask
endmodule // sef_host

// ---- tb/testbench.sv ----
// Self-checking bench for the serial EEPROM front end with a host model on the link.
// Assumes a shortened internal write time, set below.
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module testbench;
	localparam int WCYC = 200;
	// Supply-stable delay before the first access, in system clock cycles.
	localparam int PWRUP_CYC = 17500;
	logic       clk_i  = 1'b0;
	logic       rst_i  = 1'b1;
	logic       wp_n_i = 1'b1;
	logic       sck, cs_n, si, hold_n, so, so_oe, busy, write_enable_latch, stby, bad;
	logic [7:0] status;
	logic [7:0] rx[$];
	int         n_errors = 0;
	int         checks   = 0;
	int         cyc      = 0;

	always #10 clk_i = ~clk_i;

	sef_top #(.WRITE_CYCLES(WCYC)) sef_top_inst (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck),
		.cs_n_i(cs_n), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so),
		.so_oe_o(so_oe), .busy_o(busy), .write_enable_o(write_enable_latch), .standby_o(stby),
		.status_o(status));
	sef_host sef_host_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
		.so_i(so), .so_oe_i(so_oe));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic go(input logic [7:0] tx[$], input int h = -1);
		sef_host_inst.frame(tx, h, rx, bad);
		repeat (6) @(posedge clk_i);
	endtask

	task automatic settle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < WCYC + 8) begin
			@(posedge clk_i);
			n++;
		end
		`CHK("busy_end", 1'b0, busy) // write ends in time
	endtask

	task automatic write_status_cmd(input logic [7:0] v);
		go({8'h06});
		go({8'h01, v});
		settle();
	endtask

	task automatic t_idle();
		`CHK("status", 8'h00, status) // reset value
		`CHK("standby", 1'b1, stby) // idle standby
		`CHK("so_oe", 1'b0, so_oe) // output floated
		$display("test idle done");
	endtask

	task automatic t_latch();
		go({8'hFF});
		`CHK("undef_op", 8'h00, status) // opcode ignored
		go({8'h06});
		`CHK("wel_set", 1'b1, write_enable_latch) // latch set
		go({8'h05, 8'h00}, 11);
		`CHK("read_status_cmd", 8'h02, rx[1]) // resumed after pause
		`CHK("hold_float", 1'b0, bad) // floated in pause
		go({8'h04});
		`CHK("wel_clr", 1'b0, write_enable_latch) // latch cleared
		$display("test latch done");
	endtask

	task automatic t_mem();
		go({8'h02, 8'h00, 8'h04, 8'hEE});
		`CHK("no_wel", 1'b0, busy) // refused without latch
		go({8'h06});
		go({8'h02, 8'h00, 8'h04, 8'hA5, 8'h3C});
		`CHK("busy", 1'b1, busy) // write started
		`CHK("standby_busy", 1'b0, stby) // no standby while writing
		go({8'h05, 8'h00});
		`CHK("read_status_cmd_busy", 1'b1, rx[1][0]) // busy bit
		go({8'h06});
		`CHK("wel_busy", 1'b0, write_enable_latch) // ignored while busy
		settle();
		go({8'h03, 8'h00, 8'h04, 8'h00, 8'h00});
		`CHK("rd0", 8'hA5, rx[3]) // first byte
		`CHK("rd1", 8'h3C, rx[4]) // next byte
		sef_host_inst.idle_hi = 1'b1;
		go({8'h03, 8'h00, 8'h05, 8'h00});
		`CHK("rd_mode3", 8'h3C, rx[3]) // clock idles high
		sef_host_inst.idle_hi = 1'b0;
		$display("test memory done");
	endtask

	task automatic t_prot();
		write_status_cmd(8'h80);
		`CHK("pen_set", 1'b1, status[7]) // pin high allows
		@(posedge clk_i) wp_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		write_status_cmd(8'h8C);
		`CHK("wp_block", 6'h20, status[7:2]) // status write refused
		@(posedge clk_i) wp_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		write_status_cmd(8'h00);
		`CHK("wp_free", 6'h00, status[7:2]) // pin high allows
		$display("test protect done");
	endtask

	task automatic t_id();
		write_status_cmd(8'h40);
		go({8'h06});
		go({8'h02, 8'h00, 8'h05, 8'h77});
		settle();
		`CHK("idsel_clr", 1'b0, status[6]) // select dropped
		go({8'h03, 8'h00, 8'h05, 8'h00});
		`CHK("main_rd", 8'h3C, rx[3]) // main array untouched
		write_status_cmd(8'h40);
		go({8'h03, 8'h00, 8'h05, 8'h00});
		`CHK("id_rd", 8'h77, rx[3]) // page data
		write_status_cmd(8'h10);
		`CHK("lock", 1'b1, status[4]) // lock set
		write_status_cmd(8'h40);
		go({8'h06});
		go({8'h02, 8'h00, 8'h05, 8'h99});
		`CHK("lock_busy", 1'b0, busy) // write refused
		go({8'h03, 8'h00, 8'h05, 8'h00});
		`CHK("id_keep", 8'h77, rx[3]) // data kept
		$display("test id page done");
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (PWRUP_CYC) @(posedge clk_i);
		t_idle();
		t_latch();
		t_mem();
		t_prot();
		t_id();
		end_sim();
	end

	// A hang counts as a mismatch and closes the run.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			end_sim();
		end
	end
endmodule // testbench
